// >>> uart_baud_generator_pin_select_tb_top.sv
// register and rate tests for the baud generator top level
`timescale 1ns/10ps
module uart_baud_generator_pin_select_tb_top;
    logic sys_clk, sys_rst, reg_byte_wr, reg_bit_wr, reg_bit_val, reg_rd, halving, clk_src_internal;
    logic rx_hunt, rx_start_confirm, tx_data, ext_run, ext_pin, rx_pri, rx_alt, rx_line;
    logic tx_pri_out, tx_pri_oe, tx_alt_out, tx_alt_oe, sample_tick, bit_clk;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [2:0]  reg_bit_idx;
    logic [1:0]  rx_drv;
    int          fail_count = 0;
    int          num_checks = 0;
    ubg_top dut (.sys_clk, .sys_rst, .reg_addr, .reg_byte_wr, .reg_wdata, .reg_bit_wr,
        .reg_bit_idx, .reg_bit_val, .reg_rd, .reg_rdata, .oscillator_halving_select(halving),
        .clk_src_internal, .rx_hunt, .rx_start_confirm, .tx_data, .ext_baud_clock_pin(ext_pin),
        .rx_pri_pin(rx_pri), .rx_alt_pin(rx_alt), .tx_pri_out, .tx_pri_oe, .tx_alt_out,
        .tx_alt_oe, .rx_line, .sample_tick, .bit_clk);
    ubg_remote_model u_far (.ext_run, .rx_drv, .ext_baud_clock_pin(ext_pin),
        .rx_pri_pin(rx_pri), .rx_alt_pin(rx_alt));
    // 10 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = !sys_clk;
    end
    // compare and count
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            fail_count++;
        end
    endtask : chk
    // one byte write, strobe high for one cycle
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk) {reg_addr, reg_wdata, reg_byte_wr} = {a, d, 1'b1};
        @(negedge sys_clk) reg_byte_wr = 1'b0;
    endtask : wr
    // one single-bit write
    task bw(input logic [15:0] a, input logic [2:0] i, input logic v);
        @(negedge sys_clk) {reg_addr, reg_bit_idx, reg_bit_val, reg_bit_wr} = {a, i, v, 1'b1};
        @(negedge sys_clk) reg_bit_wr = 1'b0;
    endtask : bw
    // read, data is settled one cycle after the strobe
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge sys_clk) {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge sys_clk) reg_rd = 1'b0;
        chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask : rd
    // program a rate, then time one full gap between two ticks
    task meas(input logic [7:0] ctl, input logic hv, input int e);
        int n;
        halving = hv;
        wr(ubg_pkg::BAUD_CTL_ADDR, ctl);
        repeat (2)
        begin
            n = 0;
            do @(negedge sys_clk) n++; while (sample_tick !== 1'b1 && n < 20000);
        end
        chk("tick gap", e[15:0], n[15:0]);
    endtask : meas
    task final_report;
        if (fail_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    // cut a hang short
    initial
    begin
        #(95000 * 100);
        fail_count++;
        final_report();
    end
    initial
    begin
        {sys_rst, reg_byte_wr, reg_bit_wr, reg_bit_val, reg_rd, halving} = 6'b100001;
        {clk_src_internal, rx_hunt, rx_start_confirm, tx_data, ext_run} = 5'b10010;
        {reg_addr, reg_wdata, reg_bit_idx, rx_drv} = {16'h0000, 8'h00, 3'h0, 2'b11};
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        rd(ubg_pkg::BAUD_CTL_ADDR, 8'h00);
        rd(ubg_pkg::PIN_ROUTE_ADDR, 8'h00);
        wr(ubg_pkg::BAUD_CTL_ADDR, 8'h74);
        bw(ubg_pkg::BAUD_CTL_ADDR, 3'h0, 1'b1);
        rd(ubg_pkg::BAUD_CTL_ADDR, 8'h74);
        wr(ubg_pkg::PIN_ROUTE_ADDR, 8'hFF);
        rd(ubg_pkg::PIN_ROUTE_ADDR, 8'h30);
        chk("tx alt", 16'h0007, {12'h000, tx_pri_oe, tx_pri_out, tx_alt_oe, tx_alt_out});
        bw(ubg_pkg::PIN_ROUTE_ADDR, 3'h5, 1'b0);
        rd(ubg_pkg::PIN_ROUTE_ADDR, 8'h10);
        rd(16'hFF74, 8'h00);
        {rx_drv, tx_data, rx_hunt} = {2'b01, 1'b0, 1'b1};
        repeat (4) @(negedge sys_clk);
        chk("rx_line alt", 16'h0000, {15'h0000, rx_line});
        chk("tx pri", 16'h0009, {12'h000, tx_pri_oe, tx_pri_out, tx_alt_oe, tx_alt_out});
        bw(ubg_pkg::PIN_ROUTE_ADDR, 3'h4, 1'b0);
        repeat (4) @(negedge sys_clk);
        chk("rx_line pri", 16'h0001, {15'h0000, rx_line});
        rx_hunt = 1'b0;
        @(negedge sys_clk) rx_start_confirm = 1'b1;
        @(negedge sys_clk) rx_start_confirm = 1'b0;
        // every legal prescale code, ratio 16, halved input
        for (int c = 5; c <= 14; c++) meas({c[3:0], 4'h0}, 1'b1, 16 << (c - 5));
        meas(8'h00, 1'b1, 16384);
        meas(8'h5E, 1'b1, 30);
        meas(8'h50, 1'b0, 32);
        {clk_src_internal, ext_run} = 2'b01;
        meas(8'h00, 1'b1, 64);
        meas(8'h01, 1'b1, 68);
        final_report();
    end
endmodule : uart_baud_generator_pin_select_tb_top

// >>> ubg_divider.sv
// prescaler, 5-bit ratio counter and divide-by-two bit clock stage
`timescale 1ns/10ps
module ubg_divider (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // link to the register block
    ubg_gen_if.gen    gen
);
    // all divider state
    typedef struct packed {
        logic [ubg_pkg::PRESC_W-1:0] presc; // system clock prescaler
        logic [ubg_pkg::CNT_W-1:0]   cnt;   // ratio counter
        logic                        tog;   // bit clock phase
        logic                        half;  // registered wrap pulse
    } ubg_div_st_t;

    ubg_div_st_t st_q;  // registered state
    ubg_div_st_t st_d;  // next state

    logic [ubg_pkg::PRESC_W-1:0] presc_mask; // prescaler period minus one
    logic                        src_tick;   // counter source clock edge
    logic [ubg_pkg::CNT_W-1:0]   wrap_at;    // last count, k plus fifteen

    // next state: prescale, count k plus 16 source ticks, toggle
    always_comb
    begin
        presc_mask = ubg_pkg::PRESC_W'((12'h001 << gen.shift) - 12'h001);
        wrap_at    = ubg_pkg::CNT_W'(ubg_pkg::RATIO_BASE + {1'b0, gen.ratio_k} - 5'h01);
        // internal source is the prescaler, external source skips it
        src_tick   = gen.use_ext ? gen.ext_tick : (st_q.presc == presc_mask);
        st_d       = st_q;
        st_d.half  = 1'b0;
        if (gen.restart)
        begin
            // a falling rx line or a confirmed start realigns the phase
            st_d.presc = '0;
            st_d.cnt   = '0;
            st_d.tog   = 1'b0;
        end
        else
        begin
            // prescaler free runs, wrapping at its mask
            st_d.presc = (st_q.presc == presc_mask) ? '0 : st_q.presc + 1'b1;
            if (src_tick)
            begin
                if (st_q.cnt == wrap_at)
                begin
                    // reload and emit one tick; toggle halves the rate
                    st_d.cnt  = '0;
                    st_d.half = 1'b1;
                    st_d.tog  = ~st_q.tog;
                end
                else
                begin
                    st_d.cnt = st_q.cnt + 1'b1;
                end
            end
        end
    end

    // register the state
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign gen.half_tick = st_q.half;
    assign gen.bit_clk   = st_q.tog;
endmodule : ubg_divider

// >>> ubg_gen_if.sv
// control and result signals between the register block and the divider
`timescale 1ns/10ps
interface ubg_gen_if;
    logic       use_ext;    // source ticks come from the external pin
    logic       ext_tick;   // one rising edge seen on the external pin
    logic [3:0] shift;      // log2 of prescaler period in system clocks
    logic [3:0] ratio_k;    // k, divide ratio minus sixteen
    logic       restart;    // clear counter and bit clock phase
    logic       half_tick;  // counter wrapped: half a bit period
    logic       bit_clk;    // bit clock after the divide-by-two stage

    modport ctl (output use_ext, ext_tick, shift, ratio_k, restart,
                 input half_tick, bit_clk);
    modport gen (input use_ext, ext_tick, shift, ratio_k, restart,
                 output half_tick, bit_clk);
endinterface : ubg_gen_if

// >>> ubg_pkg.sv
// constants for the serial baud generator and pin routing block
package ubg_pkg;
    // register addresses on the cpu data space
    localparam logic [15:0] BAUD_CTL_ADDR   = 16'hFF73;
    localparam logic [15:0] PIN_ROUTE_ADDR  = 16'hFF75;
    // reset values
    localparam logic [7:0]  BAUD_CTL_RESET  = 8'h00;
    localparam logic [7:0]  PIN_ROUTE_RESET = 8'h00;
    // baud control fields: prescale code in the high nibble, k in the low one
    localparam int          PRESC_LSB       = 4;
    localparam int          RATIO_LSB       = 0;
    localparam int          FIELD_W         = 4;
    // pin route fields
    localparam int          RX_ALT_BIT      = 4;
    localparam int          TX_ALT_BIT      = 5;
    localparam logic [7:0]  PIN_ROUTE_MASK  = 8'h30;
    // prescale codes and exponents
    localparam logic [3:0]  PRESC_CODE_MAX  = 4'hB;
    localparam logic [3:0]  PRESC_CODE_MIN  = 4'h5;
    localparam logic [3:0]  PRESC_CODE_HI   = 4'hE;
    localparam logic [3:0]  PRESC_OFFSET    = 4'h4;
    localparam logic [3:0]  EXP_MAX         = 4'hB;
    // the 5-bit counter divides by k plus this base
    localparam logic [4:0]  RATIO_BASE      = 5'h10;
    // widths
    localparam int          PRESC_W         = 11;
    localparam int          CNT_W           = 5;
endpackage : ubg_pkg

// >>> ubg_remote_model.sv
// far side: external baud clock source and remote serial line drivers
`timescale 1ns/10ps
module ubg_remote_model (
    // bench control
    input  wire logic       ext_run,
    input  wire logic [1:0] rx_drv,
    // pins toward the device
    output logic            ext_baud_clock_pin,
    output logic            rx_pri_pin,
    output logic            rx_alt_pin
);
    // 2.5 MHz source, parked low when idle; odd phase keeps it off the sys_clk edges
    initial
    begin
        ext_baud_clock_pin = 1'b0;
        #37;
        forever #200 ext_baud_clock_pin = ext_run ? !ext_baud_clock_pin : 1'b0;
    end
    // remote transmitter levels on each rx pin
    assign rx_pri_pin = rx_drv[0];
    assign rx_alt_pin = rx_drv[1];
endmodule : ubg_remote_model

// >>> ubg_top.sv
// baud rate generator with serial pin routing, top level
`timescale 1ns/10ps
module ubg_top (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // cpu register port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_byte_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_bit_wr,
    input  wire logic [2:0]  reg_bit_idx,
    input  wire logic        reg_bit_val,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    // mode inputs from neighbouring registers
    input  wire logic        oscillator_halving_select,
    input  wire logic        clk_src_internal,
    // receiver handshake and transmit data
    input  wire logic        rx_hunt,
    input  wire logic        rx_start_confirm,
    input  wire logic        tx_data,
    // pins
    input  wire logic        ext_baud_clock_pin,
    input  wire logic        rx_pri_pin,
    input  wire logic        rx_alt_pin,
    output logic             tx_pri_out,
    output logic             tx_pri_oe,
    output logic             tx_alt_out,
    output logic             tx_alt_oe,
    // generator results
    output logic             rx_line,
    output logic             sample_tick,
    output logic             bit_clk
);
    // all register-block state
    typedef struct packed {
        logic [7:0] baud_ctl;   // baud_divider_control
        logic [7:0] route;      // serial_pin_route
        logic [7:0] rdata;      // read data
        logic       ext_s1;     // external clock synchroniser stage one
        logic       ext_s2;     // stage two
        logic       ext_prev;   // for edge detection
        logic       pri_s1;     // primary rx synchroniser
        logic       pri_s2;     // primary rx, safe to read
        logic       alt_s1;     // alternate rx synchroniser
        logic       alt_s2;     // alternate rx, safe to read
        logic       rx_prev;    // previous selected rx level
        // both tx levels are registered so the pins never glitch
        logic       tx_pri;     // primary tx pin level
        logic       tx_alt;     // alternate tx pin level
    } ubg_top_st_t;

    // one struct holds all state: one comb fill, one flop stage
    ubg_top_st_t st_q;  // registered state
    ubg_top_st_t st_d;  // next state
    ubg_gen_if   gen_if ();
    logic        rx_sel; // selected, synchronised rx level

    // prescale code to exponent n; prohibited codes fall back to n of 11
    // the halving input is applied later, as one shift less
    function automatic logic [3:0] presc_exp(input logic [3:0] code);
        logic [3:0] e;
        e = ubg_pkg::EXP_MAX;
        if (code >= ubg_pkg::PRESC_CODE_MIN && code <= ubg_pkg::PRESC_CODE_HI)
            e = code - ubg_pkg::PRESC_OFFSET;
        return e;
    endfunction : presc_exp

    // address match shared by the byte and bit write decodes
    function automatic logic reg_hit(input logic        strobe,
                                     input logic [15:0] addr,
                                     input logic [15:0] reg_at);
        // a strobe only counts when the full address matches
        return strobe && (addr == reg_at);
    endfunction : reg_hit

    // next state: registers, synchronisers, pin routing, reads
    always_comb
    begin
        // every field holds unless a branch below moves it
        st_d = st_q;
        // pins cross into the clock domain through two flops
        st_d.ext_s1   = ext_baud_clock_pin;
        st_d.ext_s2   = st_q.ext_s1;
        // the previous synced level feeds the rising edge detector
        st_d.ext_prev = st_q.ext_s2;
        // both rx pins are synchronised all the time, so a route change
        // switches between two clean levels and never a metastable one
        st_d.pri_s1   = rx_pri_pin;
        st_d.pri_s2   = st_q.pri_s1;
        st_d.alt_s1   = rx_alt_pin;
        st_d.alt_s2   = st_q.alt_s1;
        // the selected level one cycle back, for falling edge detection
        st_d.rx_prev  = rx_sel;
        // byte writes reach both registers
        if (reg_hit(reg_byte_wr, reg_addr, ubg_pkg::BAUD_CTL_ADDR))
        begin
            // the whole byte lands at once; a write during a frame upsets
            // the running rate, and nothing here guards against that
            st_d.baud_ctl = reg_wdata;
        end
        if (reg_hit(reg_byte_wr, reg_addr, ubg_pkg::PIN_ROUTE_ADDR))
        begin
            // only the two route bits are kept; the rest read back zero
            st_d.route = reg_wdata & ubg_pkg::PIN_ROUTE_MASK;
        end
        // bit writes only reach the pin route; baud control ignores them
        if (reg_hit(reg_bit_wr, reg_addr, ubg_pkg::PIN_ROUTE_ADDR))
        begin
            // set or clear one bit, then drop it again if it is unused
            st_d.route[reg_bit_idx] = reg_bit_val;
            st_d.route = st_d.route & ubg_pkg::PIN_ROUTE_MASK;
        end
        // unselected tx pin idles at mark level, undriven
        if (st_q.route[ubg_pkg::TX_ALT_BIT])
        begin
            // alternate pin carries the data, primary parks at mark
            st_d.tx_pri = 1'b1;
            st_d.tx_alt = tx_data;
        end
        else
        begin
            // primary pin carries the data, alternate parks at mark
            st_d.tx_pri = tx_data;
            st_d.tx_alt = 1'b1;
        end
        // read data, unmapped addresses return zero
        if (reg_rd)
        begin
            unique case (reg_addr)
                // baud control reads back exactly as written
                ubg_pkg::BAUD_CTL_ADDR:  st_d.rdata = st_q.baud_ctl;
                // pin route reads back with its unused bits at zero
                ubg_pkg::PIN_ROUTE_ADDR: st_d.rdata = st_q.route;
                // any other address answers zero rather than holding
                default:                 st_d.rdata = 8'h00;
            endcase
        end
        // without a read strobe the last read data stands
    end

    // rx input mux on the synchronised levels
    // the mux sits after the flops so the route bit needs no sync
    assign rx_sel = st_q.route[ubg_pkg::RX_ALT_BIT] ? st_q.alt_s2 : st_q.pri_s2;

    // register the state; both registers clear on reset
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // sync stages and tx levels start at the idle mark level, so
            // no false edge or start bit follows the release of reset
            st_q          <= '0;
            st_q.baud_ctl <= ubg_pkg::BAUD_CTL_RESET;
            st_q.route    <= ubg_pkg::PIN_ROUTE_RESET;
            st_q.ext_s1   <= 1'b1;
            st_q.ext_s2   <= 1'b1;
            st_q.ext_prev <= 1'b1;
            st_q.pri_s1   <= 1'b1;
            st_q.pri_s2   <= 1'b1;
            st_q.alt_s1   <= 1'b1;
            st_q.alt_s2   <= 1'b1;
            st_q.rx_prev  <= 1'b1;
            st_q.tx_pri   <= 1'b1;
            st_q.tx_alt   <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // divider controls; halved clock halves the prescaler period
    // the clock source bit lives in the mode register outside this block
    assign gen_if.use_ext  = ~clk_src_internal;
    // one-cycle pulse on each rising edge of the synced pin clock
    assign gen_if.ext_tick = st_q.ext_s2 & ~st_q.ext_prev;
    // shift is n, minus one when the clock is halved
    // prohibited codes already fell back to eleven in the decode
    assign gen_if.shift    = presc_exp(st_q.baud_ctl[ubg_pkg::PRESC_LSB +: ubg_pkg::FIELD_W])
                             - {3'h0, oscillator_halving_select};
    // code 1111 is undefined; it behaves as k of 15
    assign gen_if.ratio_k  = st_q.baud_ctl[ubg_pkg::RATIO_LSB +: ubg_pkg::FIELD_W];
    // hunting receiver restarts on a falling line, then on confirmation
    // a route switch while hunting can look like a falling line
    assign gen_if.restart  = (rx_hunt & st_q.rx_prev & ~rx_sel) | rx_start_confirm;

    // prescaler, ratio counter and bit clock stage
    ubg_divider u_div (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .gen     (gen_if.gen)
    );

    // outputs
    // enables follow the route bit at once, levels one cycle later
    assign reg_rdata   = st_q.rdata;
    assign tx_pri_out  = st_q.tx_pri;
    assign tx_pri_oe   = ~st_q.route[ubg_pkg::TX_ALT_BIT];
    assign tx_alt_out  = st_q.tx_alt;
    assign tx_alt_oe   = st_q.route[ubg_pkg::TX_ALT_BIT];
    assign rx_line     = rx_sel;
    assign sample_tick = gen_if.half_tick;
    assign bit_clk     = gen_if.bit_clk;
endmodule : ubg_top

// >>> ubg_top_asserts.sv
// concurrent checks on the ports of the baud generator top level
`timescale 1ns/10ps
module ubg_top_asserts (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic        reg_byte_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_bit_wr,
    input wire logic [2:0]  reg_bit_idx,
    input wire logic        reg_bit_val,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // modes, receiver handshake, tx data, pins and generator outputs
    input wire logic        clk_src_internal,
    input wire logic        rx_hunt,
    input wire logic        rx_start_confirm,
    input wire logic        tx_data,
    input wire logic        tx_pri_out,
    input wire logic        tx_alt_out,
    input wire logic        tx_pri_oe,
    input wire logic        tx_alt_oe,
    input wire logic        sample_tick,
    input wire logic        bit_clk
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] baud_s;   // shadow of the baud control register
    logic       tx_alt_s; // shadow of the tx route bit
    // shadows follow byte writes; bit writes reach only the route register
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            baud_s   <= 8'h00;
            tx_alt_s <= 1'b0;
        end
        else
        begin
            if (reg_byte_wr && reg_addr == ubg_pkg::BAUD_CTL_ADDR) baud_s <= reg_wdata;
            if (reg_byte_wr && reg_addr == ubg_pkg::PIN_ROUTE_ADDR) tx_alt_s <= reg_wdata[5];
            else if (reg_bit_wr && reg_addr == ubg_pkg::PIN_ROUTE_ADDR && reg_bit_idx == 3'h5)
                tx_alt_s <= reg_bit_val;
        end
    end
    AST_BAUD_READ: assert property (reg_rd && reg_addr == ubg_pkg::BAUD_CTL_ADDR
        |=> reg_rdata == $past(baud_s)) else $error("baud control read mismatch");
    AST_ROUTE_READ: assert property (reg_rd && reg_addr == ubg_pkg::PIN_ROUTE_ADDR
        |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:0] == 4'h0 && reg_rdata[5] == $past(tx_alt_s))
        else $error("pin route read mismatch");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_OE_ROUTE: assert property (tx_alt_oe == tx_alt_s && tx_pri_oe == !tx_alt_s)
        else $error("tx enables disagree with route bit");
    AST_TX_ALT: assert property (tx_alt_oe && $past(tx_alt_oe)
        |-> tx_alt_out == $past(tx_data) && tx_pri_out) else $error("alternate tx level wrong");
    AST_TICK_GAP: assert property (sample_tick |=> !sample_tick [*8])
        else $error("ticks closer than the minimum ratio");
    // the tick and the toggle are registered on the same edge
    AST_BITCLK_TOGGLE: assert property (sample_tick
        |-> bit_clk != $past(bit_clk)) else $error("bit clock missed a tick");
    AST_BITCLK_CAUSE: assert property ($changed(bit_clk)
        |-> sample_tick || $past(rx_start_confirm) || $past(rx_hunt))
        else $error("bit clock moved without a tick");
    // main scenarios reached
    COV_EXT_TICK: cover property (!clk_src_internal && sample_tick);
    COV_ALT_ROUTE: cover property (tx_alt_oe && reg_rd);
    COV_RESTART: cover property (rx_start_confirm ##1 !bit_clk);
endmodule : ubg_top_asserts
bind ubg_top ubg_top_asserts u_chk (.sys_clk, .sys_rst, .reg_addr, .reg_byte_wr, .reg_wdata,
    .reg_bit_wr, .reg_bit_idx, .reg_bit_val, .reg_rd, .reg_rdata, .clk_src_internal,
    .rx_hunt, .rx_start_confirm, .tx_data, .tx_pri_out, .tx_alt_out, .tx_pri_oe,
    .tx_alt_oe, .sample_tick, .bit_clk);
